// *** core/mdfe_top.sv ***
/*
 Digital front end of an eight-channel DAC: control port, mode registers,
 master clock watch, ratio detection, word/bit clock generation, serial
 receive and zero-cross volume.
 Assumes i_rst_b is the internal power-on reset and that the pins arrive
 asynchronous to the core clock; the bit clock wire is read back on i_bclk.
*/
`timescale 1ns/1ps

// Function
// - Master clock quiet 2 us or more enters power-saving, DACs down, filters reset.
// - First rising master clock edge after a stall returns to normal operation.
// - Registers keep values and take writes during power-saving.
// - After recovery volumes stay muted until the host writes the update bit.
// - Under power-on reset everything is held and control writes are dropped.
// - On reset release registers are at defaults and writes are accepted.
// - Four stereo paths, own data input each, shared word, bit and master clocks.
// - Master mode drives word and bit clocks; slave mode receives them.
// - Slave mode takes word clock and data on the rising bit clock edge.
// - Eight independent volume settings in 0.5 dB steps.
// - Each channel applies a new volume only when its signal crosses zero.
// - Control port pins are resynchronised into the core clock first.
// - Seven master clock ratios, chosen automatically in slave mode.
// - Right, left justified, I2S and DSP framing are received.
// - Ratio further than 32 master clocks from all entries falls back to 1152fs.
module mdfe_top import mdfe_pkg::*; (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_mclk,
  input  wire logic             i_bclk,
  input  wire logic             i_lrclk,
  input  wire logic [NPATH-1:0] i_serial_data_in,
  input  wire logic             i_control_clock,
  input  wire logic             i_control_data,
  input  wire logic             i_control_latch,
  output logic                  o_bclk,
  output logic                  o_bclk_oe,
  output logic                  o_lrclk,
  output logic                  o_lrclk_oe,
  output logic                  o_dac_pd,
  output logic                  o_filter_rst,
  output logic [2:0]            o_ratio,
  output logic [SW-1:0]         o_sample,
  output logic [2:0]            o_sample_ch,
  output logic                  o_sample_vld,
  output logic [NCH*8-1:0]      o_vol
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s;
  logic [4:0] prev_q, prev_d;
  logic       mclk_rise, lr_rise, cclk_rise, latch_rise;

  mdfe_sync2 #(.W(5)) u_pin_sync (
    .i_clk (i_core_clk),
    .i_d   ({i_mclk, i_lrclk, i_control_clock, i_control_data, i_control_latch}),
    .o_q   (pin_s)
  );

  always_comb begin
    prev_d     = pin_s;
    mclk_rise  = pin_s[4] & ~prev_q[4];
    lr_rise    = pin_s[3] & ~prev_q[3];
    cclk_rise  = pin_s[2] & ~prev_q[2];
    latch_rise = pin_s[0] & ~prev_q[0];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      prev_q <= pin_s; // No false edge at release when a pin idles high
    end else begin
      prev_q <= prev_d;
    end
  end

  // ----------------------------------------
  // Control port and register file
  // ----------------------------------------
  logic [CW-1:0] csh_q, csh_d;
  logic [8:0]    iface_q, iface_d;
  logic          wr;
  logic [6:0]    wr_addr;
  logic [8:0]    wr_data;
  logic          upd_wr;

  always_comb begin
    // Host keeps data stable around the rising control clock
    csh_d   = cclk_rise ? {csh_q[CW-2:0], pin_s[1]} : csh_q;
    wr      = latch_rise;
    wr_addr = csh_q[15:9];
    wr_data = csh_q[8:0];
    upd_wr  = wr && (wr_addr < REG_VOL0 + 7'(NCH)) && wr_data[VOL_UPD_BIT];
    iface_d = (wr && wr_addr == REG_IFACE) ? wr_data : iface_q;
  end

  // Synchronous reset holds all state, so writes during reset are lost
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      csh_q   <= 16'h0000;
      iface_q <= IFACE_RST;
    end else begin
      csh_q   <= csh_d;
      iface_q <= iface_d;
    end
  end

  logic master;
  assign master = iface_q[MS_BIT];

  // ----------------------------------------
  // Master clock watch
  // ----------------------------------------
  mdfe_ps_t   ps_q, ps_d;
  logic [7:0] stop_q, stop_d;
  logic       pd_q, pd_d;
  logic       ps_enter;

  always_comb begin
    stop_d = stop_q;
    ps_d   = ps_q;
    if (mclk_rise) begin
      stop_d = 8'h00;
    end else if (stop_q != STOP_CNT) begin
      stop_d = stop_q + 8'h01;
    end
    case (ps_q)
      PS_RUN: begin
        if (stop_d == STOP_CNT) begin
          ps_d = PS_SAVE;
        end
      end
      PS_SAVE: begin
        if (mclk_rise) begin
          ps_d = PS_RUN;
        end
      end
      default: ps_d = PS_RUN;
    endcase
    ps_enter = (ps_q == PS_RUN) && (ps_d == PS_SAVE);
    pd_d     = (ps_d == PS_SAVE);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      ps_q   <= PS_RUN;
      stop_q <= 8'h00;
      pd_q   <= 1'b0;
    end else begin
      ps_q   <= ps_d;
      stop_q <= stop_d;
      pd_q   <= pd_d;
    end
  end

  // ----------------------------------------
  // Ratio detection
  // ----------------------------------------
  function automatic logic [2:0] pick(input logic [10:0] n);
    int d;
    pick = RATIO_FALLBACK;
    for (int i = 0; i < RATIO_N; i++) begin
      d = int'(n) - RATIO_TAB[i];
      if (d <= RATIO_TOL && d >= -RATIO_TOL) begin
        pick = 3'(i);
      end
    end
  endfunction : pick

  logic [10:0] mcnt_q, mcnt_d;
  logic [2:0]  ratio_q, ratio_d;
  logic [2:0]  mrat;

  // Counting relies on the core clock oversampling the master clock
  always_comb begin
    mrat    = iface_q[MRAT_LSB +: 3];
    mcnt_d  = mcnt_q;
    ratio_d = ratio_q;
    if (lr_rise) begin
      mcnt_d = 11'(mclk_rise);
    end else if (mclk_rise && mcnt_q != MCNT_MAX) begin
      mcnt_d = mcnt_q + 11'h001;
    end
    if (master) begin
      ratio_d = (mrat > RATIO_FALLBACK) ? RATIO_FALLBACK : mrat;
    end else if (lr_rise) begin
      ratio_d = pick(mcnt_q);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      mcnt_q  <= 11'h000;
      ratio_q <= RATIO_FALLBACK;
    end else begin
      mcnt_q  <= mcnt_d;
      ratio_q <= ratio_d;
    end
  end

  // ----------------------------------------
  // Master mode clock generation
  // ----------------------------------------
  logic [1:0] bdiv_q, bdiv_d;
  logic [5:0] lrcnt_q, lrcnt_d;
  logic       bclk_q, bclk_d;
  logic       lrclk_q, lrclk_d;
  logic       oe_q, oe_d;

  // Derived from the core clock so the link clock exists without a master clock
  always_comb begin
    bdiv_d  = bdiv_q;
    lrcnt_d = lrcnt_q;
    bclk_d  = bclk_q;
    lrclk_d = lrclk_q;
    oe_d    = master;
    if (!master) begin
      bdiv_d  = 2'h0;
      lrcnt_d = 6'h00;
      bclk_d  = 1'b0;
      lrclk_d = 1'b0;
    end else begin
      bdiv_d = bdiv_q + 2'h1;
      if (bdiv_q == BDIV_LAST) begin
        bclk_d = ~bclk_q;
        // Word clock moves on the falling bit clock edge
        if (bclk_q) begin
          lrcnt_d = lrcnt_q + 6'h01;
          if (lrcnt_q == LR_LAST) begin
            lrcnt_d = 6'h00;
            lrclk_d = ~lrclk_q;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      bdiv_q  <= 2'h0;
      lrcnt_q <= 6'h00;
      bclk_q  <= 1'b0;
      lrclk_q <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      bdiv_q  <= bdiv_d;
      lrcnt_q <= lrcnt_d;
      bclk_q  <= bclk_d;
      lrclk_q <= lrclk_d;
      oe_q    <= oe_d;
    end
  end

  // ----------------------------------------
  // Serial receive on the bit clock domain
  // ----------------------------------------
  logic [4:0]        bsync;
  logic [NCH*SW-1:0] frame;
  logic              frame_tgl;
  logic              tgl_s;

  mdfe_sync2 #(.W(5)) u_bclk_sync (
    .i_clk (i_bclk),
    .i_d   ({i_rst_b, iface_q[FMT_LSB +: 2], iface_q[WL_LSB +: 2]}),
    .o_q   (bsync)
  );

  mdfe_serial_rx u_rx (
    .i_bclk      (i_bclk),
    .i_rst_b     (bsync[4]),
    .i_lrclk     (i_lrclk),
    .i_din       (i_serial_data_in),
    .i_fmt       (bsync[3:2]),
    .i_wl        (bsync[1:0]),
    .o_frame     (frame),
    .o_frame_tgl (frame_tgl)
  );

  mdfe_sync2 #(.W(1)) u_tgl_sync (
    .i_clk (i_core_clk),
    .i_d   (frame_tgl),
    .o_q   (tgl_s)
  );

  // ----------------------------------------
  // Frame capture and sample emission
  // ----------------------------------------
  logic              tprev_q, tprev_d;
  logic [NCH*SW-1:0] fbuf_q, fbuf_d;
  logic              emit_q, emit_d;
  logic [2:0]        ch_q, ch_d;
  logic [SW-1:0]     smp_q, smp_d;
  logic [2:0]        sch_q, sch_d;
  logic              svld_q, svld_d;
  logic              new_frame;

  // Frame bus is held a whole frame, so sampling it after the toggle is safe
  always_comb begin
    tprev_d   = tgl_s;
    new_frame = (tgl_s ^ tprev_q) && (ps_q == PS_RUN);
    fbuf_d    = new_frame ? frame : fbuf_q;
    emit_d    = emit_q;
    ch_d      = ch_q;
    if (new_frame) begin
      emit_d = 1'b1;
      ch_d   = 3'h0;
    end else if (emit_q) begin
      ch_d = ch_q + 3'h1;
      if (ch_q == 3'h7) begin
        emit_d = 1'b0;
      end
    end
    if (ps_q == PS_SAVE) begin
      emit_d = 1'b0;
    end
    svld_d = emit_q && (ps_q == PS_RUN);
    sch_d  = ch_q;
    smp_d  = fbuf_q[ch_q*SW +: SW];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      tprev_q <= 1'b0;
      fbuf_q  <= '0;
      emit_q  <= 1'b0;
      ch_q    <= 3'h0;
      smp_q   <= 24'h00_0000;
      sch_q   <= 3'h0;
      svld_q  <= 1'b0;
    end else begin
      tprev_q <= tprev_d;
      fbuf_q  <= fbuf_d;
      emit_q  <= emit_d;
      ch_q    <= ch_d;
      smp_q   <= smp_d;
      sch_q   <= sch_d;
      svld_q  <= svld_d;
    end
  end

  // ----------------------------------------
  // Per-channel volume with zero-cross update
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_vol
    logic [7:0]    set_q, set_d;
    logic [7:0]    app_q, app_d;
    logic          pend_q, pend_d;
    logic          sign_q, sign_d;
    logic [SW-1:0] s;
    logic          here, zc;

    always_comb begin
      s      = fbuf_q[c*SW +: SW];
      here   = emit_q && (ch_q == 3'(c)) && (ps_q == PS_RUN);
      zc     = (s == 24'h00_0000) || (s[SW-1] != sign_q);
      set_d  = (wr && wr_addr == REG_VOL0 + 7'(c)) ? wr_data[7:0] : set_q;
      sign_d = here ? s[SW-1] : sign_q;
      app_d  = (here && pend_q && zc) ? set_q : app_q;
      pend_d = (here && zc) ? 1'b0 : pend_q;
      if (ps_enter) begin
        app_d  = VOL_MUTE;
        pend_d = 1'b0;
      end
      // A fresh update wins over the clear in the same cycle
      if (upd_wr) begin
        pend_d = 1'b1;
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
        set_q  <= VOL_RST;
        app_q  <= VOL_RST;
        pend_q <= 1'b0;
        sign_q <= 1'b0;
      end else begin
        set_q  <= set_d;
        app_q  <= app_d;
        pend_q <= pend_d;
        sign_q <= sign_d;
      end
    end

    assign o_vol[c*8 +: 8] = app_q;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_bclk       = bclk_q;
  assign o_bclk_oe    = oe_q;
  assign o_lrclk      = lrclk_q;
  assign o_lrclk_oe   = oe_q;
  assign o_dac_pd     = pd_q;
  assign o_filter_rst = pd_q;
  assign o_ratio      = ratio_q;
  assign o_sample     = smp_q;
  assign o_sample_ch  = sch_q;
  assign o_sample_vld = svld_q;

endmodule : mdfe_top

// *** core/mdfe_pkg.sv ***
/*
 Shared constants and types of the DAC digital front end.
 Assumes a 100 MHz core clock; the power-saving stop count is derived from it, the bit clock divider is fixed.
*/
package mdfe_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CORE_HZ     = 100_000_000;
  localparam int         STOP_MIN_NS = 2000;
  localparam int         STOP_CYC    = (STOP_MIN_NS * (CORE_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] STOP_CNT    = 8'(STOP_CYC);
  // Generated bit clock: four core cycles per half period
  localparam logic [1:0] BDIV_LAST   = 2'h3;
  localparam logic [5:0] LR_LAST     = 6'h1f;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NPATH = 4;
  localparam int NCH   = 8;
  localparam int SW    = 24;
  localparam int CW    = 16;

  // ----------------------------------------
  // Control word map: [15:9] address, [8:0] data
  // ----------------------------------------
  localparam logic [6:0] REG_VOL0    = 7'h00;
  localparam logic [6:0] REG_IFACE   = 7'h08;
  localparam int         VOL_UPD_BIT = 8;
  localparam int         FMT_LSB     = 0;
  localparam int         WL_LSB      = 2;
  localparam int         MS_BIT      = 4;
  localparam int         MRAT_LSB    = 5;
  localparam logic [7:0] VOL_RST     = 8'hff;
  localparam logic [7:0] VOL_MUTE    = 8'h00;
  localparam logic [8:0] IFACE_RST   = 9'h00a;

  // ----------------------------------------
  // Master clock ratios
  // ----------------------------------------
  localparam int          RATIO_TOL      = 32;
  localparam int          RATIO_N        = 7;
  localparam int          RATIO_TAB [7]  = '{128, 192, 256, 384, 512, 768, 1152};
  localparam logic [2:0]  RATIO_FALLBACK = 3'h6;
  localparam logic [10:0] MCNT_MAX       = 11'h7ff;

  typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} mdfe_fmt_t;
  typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} mdfe_wl_t;
  typedef enum logic {PS_RUN, PS_SAVE} mdfe_ps_t;

endpackage : mdfe_pkg

// *** core/mdfe_sync2.sv ***
/*
 Two flip-flop level synchroniser.
 Assumes each bit is a slow level or a signal sampled well above its rate.
*/
`timescale 1ns/1ps
module mdfe_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic [W-1:0]      o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end

  assign o_q = sync_q;

endmodule : mdfe_sync2

// *** core/mdfe_serial_rx.sv ***
/*
 Serial audio receiver on the bit clock: four stereo inputs, four framings.
 Assumes reset and format settings arrive already synchronised to i_bclk.
*/
`timescale 1ns/1ps
module mdfe_serial_rx import mdfe_pkg::*; (
  input  wire logic              i_bclk,
  input  wire logic              i_rst_b,
  input  wire logic              i_lrclk,
  input  wire logic [NPATH-1:0]  i_din,
  input  wire logic [1:0]        i_fmt,
  input  wire logic [1:0]        i_wl,
  output logic [NCH*SW-1:0]      o_frame,
  output logic                   o_frame_tgl
);

  function automatic logic [SW-1:0] align(input logic [31:0] w, input logic [1:0] wl);
    case (wl)
      WL_16:   align = {w[15:0], 8'h00};
      WL_20:   align = {w[19:0], 4'h0};
      WL_24:   align = w[23:0];
      default: align = w[31:8];
    endcase
  endfunction : align

  logic              lr_q, lr_d;
  logic [6:0]        pos_q, pos_d;
  logic              tgl_q, tgl_d;
  logic [6:0]        wlen;
  logic              restart;
  logic              ldone, rdone;

  // ----------------------------------------
  // Bit position and word boundaries
  // ----------------------------------------
  always_comb begin
    case (i_wl)
      WL_16:   wlen = 7'h10;
      WL_20:   wlen = 7'h14;
      WL_24:   wlen = 7'h18;
      default: wlen = 7'h20;
    endcase
    // DSP framing restarts only on the rising sync pulse
    restart = (i_fmt == FMT_DSP) ? (i_lrclk & ~lr_q) : (i_lrclk ^ lr_q);
    pos_d   = restart ? 7'h00 : ((pos_q == 7'h7f) ? pos_q : pos_q + 7'h01);
    ldone   = 1'b0;
    rdone   = 1'b0;
    case (i_fmt)
      FMT_RJ: begin
        ldone = restart & lr_q;
        rdone = restart & ~lr_q;
      end
      FMT_LJ: begin
        ldone = (pos_d == wlen - 7'h01) & i_lrclk;
        rdone = (pos_d == wlen - 7'h01) & ~i_lrclk;
      end
      FMT_I2S: begin
        ldone = (pos_d == wlen) & ~i_lrclk;
        rdone = (pos_d == wlen) & i_lrclk;
      end
      default: begin
        ldone = (pos_d == wlen);
        rdone = (pos_d == {wlen[5:0], 1'b0});
      end
    endcase
    lr_d  = i_lrclk;
    tgl_d = tgl_q ^ rdone;
  end

  // Data and word clock are taken on the rising bit clock edge
  always_ff @(posedge i_bclk) begin
    if (!i_rst_b) begin
      lr_q  <= 1'b0;
      pos_q <= 7'h7f;
      tgl_q <= 1'b0;
    end else begin
      lr_q  <= lr_d;
      pos_q <= pos_d;
      tgl_q <= tgl_d;
    end
  end

  // ----------------------------------------
  // Per-path shifters
  // ----------------------------------------
  for (genvar p = 0; p < NPATH; p++) begin : g_path
    logic [31:0]   sh_q, sh_d;
    logic [SW-1:0] left_q, left_d;
    logic [SW-1:0] word;
    logic [2*SW-1:0] pair_q, pair_d;

    always_comb begin
      sh_d   = {sh_q[30:0], i_din[p]};
      // Right justified words end before the boundary bit
      word   = align((i_fmt == FMT_RJ) ? sh_q : sh_d, i_wl);
      left_d = ldone ? word : left_q;
      pair_d = rdone ? {word, left_q} : pair_q;
    end

    always_ff @(posedge i_bclk) begin
      if (!i_rst_b) begin
        sh_q   <= 32'h0000_0000;
        left_q <= 24'h00_0000;
        pair_q <= 48'h0000_0000_0000;
      end else begin
        sh_q   <= sh_d;
        left_q <= left_d;
        pair_q <= pair_d;
      end
    end

    assign o_frame[p*2*SW +: 2*SW] = pair_q;
  end

  assign o_frame_tgl = tgl_q;

endmodule : mdfe_serial_rx

// *** testbench/mdfe_sva.sv ***
/*
 Port checker for mdfe_top: reset, power saving, sample bursts, volume, clocks.
 Assumes one core clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module mdfe_sva import mdfe_pkg::*; (
  input wire logic             i_core_clk,
  input wire logic             i_rst_b,
  input wire logic             i_mclk,
  input wire logic             o_bclk,
  input wire logic             o_bclk_oe,
  input wire logic             o_lrclk,
  input wire logic             o_lrclk_oe,
  input wire logic             o_dac_pd,
  input wire logic             o_filter_rst,
  input wire logic [2:0]       o_ratio,
  input wire logic [2:0]       o_sample_ch,
  input wire logic             o_sample_vld,
  input wire logic [NCH*8-1:0] o_vol
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Cycles since the raw master clock last rose, saturating
  logic       mclk_q, mclk_d;
  logic [8:0] quiet_q, quiet_d;
  always_comb begin
    mclk_d  = i_rst_b ? i_mclk : 1'b0;
    quiet_d = (i_mclk && !mclk_q) ? 9'h000 : quiet_q + {8'h00, quiet_q != 9'h1ff};
    if (!i_rst_b) quiet_d = 9'h000;
  end
  always_ff @(posedge i_core_clk) begin
    mclk_q  <= mclk_d;
    quiet_q <= quiet_d;
  end
  property p_reset_vals;
    disable iff (1'b0) !i_rst_b |=> o_ratio == 3'h6 && o_vol == {NCH{VOL_RST}}
      && !o_dac_pd && !o_bclk_oe && !o_sample_vld;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_pd_entry; quiet_q == 9'h0d2 |-> o_dac_pd; endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("no power saving");
  property p_pd_early; $rose(o_dac_pd) |-> quiet_q >= 9'h0c8; endproperty
  a_pd_early: assert property (p_pd_early) else $error("power saving too early");
  property p_pd_filt; o_filter_rst == o_dac_pd; endproperty
  a_pd_filt: assert property (p_pd_filt) else $error("filter reset apart");
  property p_pd_exit; o_dac_pd && i_mclk && !mclk_q |-> ##[1:6] !o_dac_pd; endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("no recovery");
  property p_pd_mute; o_dac_pd [*3] |-> o_vol == '0 && !o_sample_vld; endproperty
  a_pd_mute: assert property (p_pd_mute) else $error("active in power saving");
  property p_burst; $rose(o_sample_vld) |-> o_sample_ch == 3'h0 ##0 o_sample_vld [*8]
    ##1 !o_sample_vld; endproperty
  a_burst: assert property (p_burst) else $error("bad burst");
  property p_ch_step; o_sample_vld && $past(o_sample_vld) |->
    o_sample_ch == $past(o_sample_ch) + 3'h1; endproperty
  a_ch_step: assert property (p_ch_step) else $error("channel order");
  property p_vol_zc; $changed(o_vol[7:0]) && !o_dac_pd && $past(i_rst_b) |->
    (o_sample_vld && o_sample_ch == 3'h0) || ($past(o_sample_vld) && $past(o_sample_ch) == 3'h0);
  endproperty
  a_vol_zc: assert property (p_vol_zc) else $error("volume off sample");
  property p_oe_pair; o_bclk_oe == o_lrclk_oe && (o_bclk_oe || !o_bclk); endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock drive");
  property p_bclk_rate; o_bclk_oe && $changed(o_bclk) |=> $stable(o_bclk) [*3]; endproperty
  a_bclk_rate: assert property (p_bclk_rate) else $error("bit clock rate");
  property p_lr_edge; o_lrclk_oe && $changed(o_lrclk) |-> $fell(o_bclk); endproperty
  a_lr_edge: assert property (p_lr_edge) else $error("word clock off bit clock fall");
  c_pd: cover property ($rose(o_dac_pd));
  c_burst: cover property (o_sample_vld && o_sample_ch == 3'h7);
  c_master: cover property ($rose(o_bclk_oe));
endmodule : mdfe_sva

// *** testbench/mdfe_far_end.sv ***
/*
 Far-end serial audio source: I2S or left justified, 24-bit words, 32 clocks a half.
 Assumes the bench calls its tasks; the bit clock stands still between them.
*/
`timescale 1ns/1ps
module mdfe_far_end import mdfe_pkg::*; (
  output logic             o_bclk,
  output logic             o_lrclk,
  output logic [NPATH-1:0] o_din
);
  initial begin
    o_bclk  = 1'b0;
    o_lrclk = 1'b1;
    o_din   = '0;
  end
  // Lines move with the falling bit clock so they stand 80 ns round the rise
  task automatic bit_out(input logic lr, input logic [NPATH-1:0] d);
    o_bclk  = 1'b0;
    o_lrclk = lr;
    o_din   = d;
    #80 o_bclk = 1'b1;
    #80;
  endtask : bit_out
  task automatic clocks(input int n);
    repeat (n) bit_out(1'b1, ~o_din);
    o_bclk = 1'b0;
  endtask : clocks
  task automatic send_frame(input logic [NCH*SW-1:0] s, input bit lj);
    logic [NPATH-1:0] d;
    int               o;
    o = lj ? 0 : 1;
    #3.3;
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < 32; i++) begin
        for (int p = 0; p < NPATH; p++)
          d[p] = (i >= o && i < o + SW) ? s[(2*p+h)*SW+SW-1-i+o] : 1'b0;
        bit_out(h[0] ^ lj, d);
      end
    end
    o_bclk = 1'b0;
    // Released data shows the inverse, never a stale copy
    o_din  = ~o_din;
  endtask : send_frame
endmodule : mdfe_far_end

// *** testbench/mdfe_top_tb.sv ***
/*
 Self-checking bench for mdfe_top with a queue model of samples and volumes.
 Assumes mdfe_far_end as the serial source and mdfe_sva bound at the foot.
*/
`timescale 1ns/1ps
module mdfe_top_tb import mdfe_pkg::*;;
  logic             clk, rst_b, cclk, cdata, clatch, fbclk, flr, boe, loe, bo, lo, pd, frst, vld;
  logic             mclk = 1'b0;
  logic             mrun = 1'b1;
  logic             lj = 1'b0;
  realtime          mhalf = 20.0;
  realtime          halves[4] = '{40.0, 26.667, 20.0, 16.0};
  logic [2:0]       exp_r[4] = '{3'h0, 3'h1, 3'h2, RATIO_FALLBACK};
  logic [NPATH-1:0] fdin;
  logic [2:0]       ratio, ch;
  logic [SW-1:0]    smp;
  logic [NCH*8-1:0] vol;
  logic [SW+2:0]    q[$];
  logic [7:0]       vreg[NCH], vexp[NCH];
  logic             pend[NCH], sgn[NCH];
  int               n_mismatch, check_count, seed;
  mdfe_far_end mdfe_far_end_inst (.o_bclk(fbclk), .o_lrclk(flr), .o_din(fdin));
  mdfe_top mdfe_top_inst (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_mclk(mclk), .i_bclk(boe ? bo : fbclk),
    .i_lrclk(loe ? lo : flr), .i_serial_data_in(fdin), .i_control_clock(cclk),
    .i_control_data(cdata), .i_control_latch(clatch), .o_bclk(bo), .o_bclk_oe(boe),
    .o_lrclk(lo), .o_lrclk_oe(loe), .o_dac_pd(pd), .o_filter_rst(frst), .o_ratio(ratio),
    .o_sample(smp), .o_sample_ch(ch), .o_sample_vld(vld), .o_vol(vol));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial forever begin
    #(mhalf);
    if (mrun) mclk = ~mclk;
  end
  // ----
  // Tasks
  // ----
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [NCH*8+7:0] got, input logic [NCH*8+7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic vol_check();
    for (int c = 0; c < NCH; c++) check(vol[8*c +: 8], vexp[c]);
  endtask : vol_check
  task automatic mreset();
    vreg = '{default: VOL_RST};
    vexp = '{default: VOL_RST};
    pend = '{default: 1'b0};
    sgn  = '{default: 1'b0};
  endtask : mreset
  task automatic cwrite(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {a, d};
    if (rst_b === 1'b1 && a < REG_IFACE) begin
      vreg[a[2:0]] = d[7:0];
      if (d[VOL_UPD_BIT]) pend = '{default: 1'b1};
    end
    for (int i = 15; i >= 0; i--) begin
      cclk  = 1'b0;
      cdata = w[i];
      step(4);
      cclk = 1'b1;
      step(4);
    end
    step(2);
    clatch = 1'b1;
    step(5);
    clatch = 1'b0;
    step(5);
  endtask : cwrite
  task automatic frame(input bit real_frame, input bit zero);
    logic [NCH*SW-1:0] s;
    for (int c = 0; c < NCH; c++) begin
      s[c*SW +: SW] = zero ? '0 : {1'b0, 23'($random(seed)) | 23'h1};
      if (real_frame) q.push_back({3'(c), s[c*SW +: SW]});
    end
    mdfe_far_end_inst.send_frame(s, lj);
    step(20);
  endtask : frame
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Model of sample order and zero-cross volume update
  always @(posedge clk) begin : mon
    logic [SW+2:0] e;
    int            c;
    if (vld === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      c = int'(e[SW+2:SW]);
      check({ch, smp}, e);
      if (pend[c] && (e[SW-1:0] == '0 || e[SW-1] != sgn[c])) begin
        vexp[c] = vreg[c];
        pend[c] = 1'b0;
      end
      sgn[c] = e[SW-1];
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    {rst_b, cclk, cdata, clatch} = 4'h0;
    {n_mismatch, check_count} = '0;
    seed = 32'h30214aac;
    mreset();
    step(12);
    // The bit clock side leaves reset only on its own edges
    mdfe_far_end_inst.clocks(4);
    step(1);
    rst_b = 1'b1;
    check({ratio, vol, pd, frst, boe, loe}, {3'h6, {NCH{VOL_RST}}, 4'h0});
    frame(1'b0, 1'b0);
    for (int c = 0; c < NCH; c++) cwrite(REG_VOL0 + 7'(c), {1'b0, 8'(c*16+8)});
    frame(1'b1, 1'b0);
    vol_check();
    cwrite(REG_VOL0, {1'b1, 8'h08});
    frame(1'b1, 1'b0);
    vol_check();
    frame(1'b1, 1'b1);
    vol_check();
    mrun = 1'b0;
    step(215);
    check({pd, frst}, 2'b11);
    pend = '{default: 1'b0};
    vexp = '{default: VOL_MUTE};
    vol_check();
    cwrite(REG_VOL0 + 7'h3, {1'b0, 8'h40});
    frame(1'b0, 1'b1);
    mrun = 1'b1;
    step(12);
    check(pd, 1'b0);
    frame(1'b1, 1'b1);
    vol_check();
    cwrite(REG_VOL0 + 7'h1, {1'b1, 8'h28});
    frame(1'b1, 1'b1);
    vol_check();
    for (int k = 0; k < 4; k++) begin
      mhalf = halves[k];
      repeat (3) frame(1'b1, 1'b0);
      check(ratio, exp_r[k]);
    end
    mhalf = 20.0;
    // First frame after a format change is not aligned, so it is not modelled
    cwrite(REG_IFACE, 9'h009);
    lj = 1'b1;
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b0);
    lj = 1'b0;
    rst_b = 1'b0;
    cwrite(REG_VOL0 + 7'h2, {1'b1, 8'h11});
    mdfe_far_end_inst.clocks(4);
    step(1);
    rst_b = 1'b1;
    mreset();
    frame(1'b0, 1'b1);
    frame(1'b1, 1'b1);
    vol_check();
    cwrite(REG_IFACE, 9'h07a);
    step(10);
    check({boe, loe, ratio}, {2'b11, 3'h3});
    step(600);
    check(q.size(), 0);
    report_and_stop();
  end
  initial begin
    #600_000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : mdfe_top_tb
bind mdfe_top mdfe_sva mdfe_sva_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_mclk(i_mclk), .o_bclk(o_bclk), .o_bclk_oe(o_bclk_oe), .o_lrclk(o_lrclk),
  .o_lrclk_oe(o_lrclk_oe),
  .o_dac_pd(o_dac_pd), .o_filter_rst(o_filter_rst), .o_ratio(o_ratio),
  .o_sample_ch(o_sample_ch), .o_sample_vld(o_sample_vld), .o_vol(o_vol));
